//--- bench/cfg_port_asserts.sv
// checker: wire relations on the link between host and device ends
// assumes one CLOCK domain; instantiated beside the link interface
module cfg_port_asserts (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic shift_clock_format_pin,
	input wire logic port_select_n,
	input wire logic host_sdio_out,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_out,
	input wire logic dev_sdio_oe,
	input wire logic serial_io_stabilizer_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// short aliases, keeps each property but p_launch on one line
	// ----------------------------------------------------------------
	wire sc = shift_clock_format_pin; // link clock
	wire cs = port_select_n; // select, active low
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	// lead-in: clock low under select before first rise
	sequence s_lead;
		(!sc && !cs) [*7];
	endsequence
	property p_lead; $fell(cs) |-> s_lead; endproperty
	a_lead: assert property (p_lead) else $error("clock rose early");
	property p_in_frame; $rose(sc) |-> !cs; endproperty
	a_in_frame: assert property (p_in_frame) else $error("clock outside frame");
	property p_high; $rose(sc) |=> sc [*7]; endproperty
	a_high: assert property (p_high) else $error("clock high too short");
	// host data may only move away from the rising edge
	property p_host_hold; $rose(sc) && host_sdio_oe |-> $stable(host_sdio_out); endproperty
	a_host_hold: assert property (p_host_hold) else $error("host data moved");
	property p_launch;
		dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_out) |-> !sc;
	endproperty
	a_launch: assert property (p_launch) else $error("read bit off fall");
	// a driven clash would hide the host value behind the device value
	property p_clash; !(host_sdio_oe && dev_sdio_oe); endproperty
	a_clash: assert property (p_clash) else $error("both drive data");
	property p_turn; $rose(dev_sdio_oe) |-> !cs && !sc && !host_sdio_oe; endproperty
	a_turn: assert property (p_turn) else $error("bad turnaround");
	property p_host_drv; $fell(cs) |-> host_sdio_oe; endproperty
	a_host_drv: assert property (p_host_drv) else $error("host not driving");
	property p_release; $rose(cs) |-> ##[0:8] !dev_sdio_oe; endproperty
	a_release: assert property (p_release) else $error("data not released");
endmodule

//--- bench/converter_serial_config_port_bench.sv
// bench: host and device ends joined by the link, driven over axi4-lite
// assumes the host answers every axi request; a watchdog ends a hang
module converter_serial_config_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0;
	logic [7:0] awaddr = 0, araddr = 0, phase;
	logic [31:0] wdata = 0, rdata, d;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, twos, stab, strap, lsb;
	logic [1:0] bresp, rresp, r;
	int fails = 0, num_checks = 0;
	cfg_port_if cfg_port_if_i ();
	initial forever #4 clk = ~clk;
	cfg_port_device cfg_port_device_i (.CLOCK(clk), .RST_N(rst_n), .LINK(cfg_port_if_i),
		.FORMAT_TWOS(twos), .STABILIZER_EN(stab), .STRAP_MODE(strap), .LSB_FIRST(lsb),
		.PHASE_ADJ(phase));
	cfg_port_host cfg_port_host_i (.CLOCK(clk), .RST_N(rst_n), .LINK(cfg_port_if_i),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	cfg_port_asserts cfg_port_asserts_i (.CLOCK(clk), .RST_N(rst_n),
		.shift_clock_format_pin(cfg_port_if_i.shift_clock_format_pin),
		.port_select_n(cfg_port_if_i.port_select_n),
		.host_sdio_out(cfg_port_if_i.host_sdio_out), .host_sdio_oe(cfg_port_if_i.host_sdio_oe),
		.dev_sdio_out(cfg_port_if_i.dev_sdio_out), .dev_sdio_oe(cfg_port_if_i.dev_sdio_oe),
		.serial_io_stabilizer_pin(cfg_port_if_i.serial_io_stabilizer_pin));
	// ----------------------------------------------------------------
	// compare, axi cycles and frames
	// ----------------------------------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// address and data offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
		r = bresp;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rready <= 0;
		d = rdata;
		r = rresp;
	endtask
	// one serial frame; polls done, then fetches read bytes
	task frame(input logic [15:0] ins, input logic [31:0] v);
		wr(8'h04, v);
		wr(8'h00, {16'h0, ins});
		rd(8'h0c);
		while (d[1] !== 1'b1) rd(8'h0c);
		rd(8'h08);
	endtask
	task finish_test;
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests: select high at power-up, then frames
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (8) @(posedge clk);
		chk("strap", 1, strap);
		chk("stab", 1, stab);
		chk("twos", 0, twos);
		chk("phase", 0, phase);
		frame(16'h0014, 32'ha5);
		chk("strap", 0, strap);
		chk("phase", 0, phase);
		frame(16'h00ff, 32'h1);
		chk("phase", 8'ha5, phase);
		frame(16'h8014, 0);
		chk("rd14", 8'ha5, d[7:0]);
		frame(16'ha001, 0);
		chk("rd01", 16'h185a, d[15:0]);
		// streaming: four bytes, address falling
		frame(16'h6014, 32'h44332211);
		frame(16'ha013, 0);
		chk("stream", 16'h3322, d[15:0]);
		chk("phase", 8'ha5, phase);
		frame(16'h0000, 32'h42);
		wr(8'h10, 1);
		chk("wok", 2'h0, r);
		frame(16'h8000, 0);
		chk("cfg", 8'h5a, d[7:0]);
		chk("lsb", 1, lsb);
		frame(16'ha013, 0);
		chk("lsbrd", 16'h1122, d[15:0]);
		frame(16'h8005, 0);
		chk("open", 8'h00, d[7:0]);
		wr(8'h08, 0);
		chk("wro", 2'h2, r);
		rd(8'h20);
		chk("unmapped", 2'h2, r);
		chk("unmapped", 0, d);
		finish_test();
	end
	initial begin
		#200000;
		fails++;
		finish_test();
	end
endmodule

//--- logic/cfg_port_cfg.svh
// constants of the converter serial configuration port: offsets, fields, resets, timing
// assumes inclusion by both ends of the link and by nothing that redefines these names
`ifndef CFG_PORT_CFG_SVH
`define CFG_PORT_CFG_SVH

// ----------------------------------------------------------------
// instruction layout
// ----------------------------------------------------------------
`define INSTR_BITS 16
`define WORD_BITS 8
`define INS_RW 15
`define INS_WLEN_HI 14
`define INS_WLEN_LO 13
`define WLEN_STREAM 2'h3

// ----------------------------------------------------------------
// device register map
// ----------------------------------------------------------------
`define ADDR_PORT_CFG 13'h0000
`define ADDR_CHIP_ID 13'h0001
`define ADDR_CHIP_GRADE 13'h0002
`define ADDR_FUNC_LO 13'h0008
`define ADDR_FUNC_HI 13'h0018
`define ADDR_PHASE 13'h0014
`define ADDR_UPDATE 13'h00ff
`define FUNC_COUNT 17
`define PORT_CFG_RST 8'h18
`define FUNC_RST 8'h00
`define PHASE_RST 8'h00
`define CFG_LSB_HI 6
`define CFG_SRST_HI 5
`define CFG_SRST_LO 2
`define CFG_LSB_LO 1
`define GRADE_CHILD 3
`define UPD_XFER 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define STRAP_WAIT 2'h3
`define CLK_PERIOD_NS 8
`define SCLK_PERIOD_NS 128
`define SCLK_HALF_CYC (`SCLK_PERIOD_NS / `CLK_PERIOD_NS / 2)

// ----------------------------------------------------------------
// host register map (axi4-lite byte offsets)
// ----------------------------------------------------------------
`define HREG_INSTR 8'h00
`define HREG_WDATA 8'h04
`define HREG_RDATA 8'h08
`define HREG_STATUS 8'h0c
`define HREG_CTRL 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/cfg_port_device.sv
// converter configuration port: serial frame decode and register map
// assumes the shift clock is much slower than CLOCK (at least 8 cycles per half period)
`include "cfg_port_cfg.svh"
module cfg_port_device
	import cfg_port_pkg::*;
#(
	parameter byte_t CHIP_ID = 8'h5a, // arbitrary value
	parameter logic CHIP_CHILD = 1'b0 // arbitrary value
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	cfg_port_if.dev LINK,
	output logic FORMAT_TWOS,
	output logic STABILIZER_EN,
	output logic STRAP_MODE,
	output logic LSB_FIRST,
	output logic [7:0] PHASE_ADJ
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic sclk_lvl, sclk_rise, sclk_fall; // synchronised shift clock
	logic sel_lvl; // synchronised select
	logic sdio_lvl; // synchronised data line

	sync_edge u_sclk (.clk(CLOCK), .rst_n(RST_N), .din(LINK.shift_clock_format_pin),
		.level(sclk_lvl), .rise(sclk_rise), .fall(sclk_fall));
	sync_edge u_sel (.clk(CLOCK), .rst_n(RST_N), .din(LINK.port_select_n),
		.level(sel_lvl), .rise(), .fall());
	sync_edge u_sdio (.clk(CLOCK), .rst_n(RST_N), .din(LINK.serial_io_stabilizer_pin),
		.level(sdio_lvl), .rise(), .fall());

	// ----------------------------------------------------------------
	// power-up strap capture
	// ----------------------------------------------------------------
	logic [1:0] strap_wait_ff; // lets the synchroniser fill after reset
	logic strap_done_ff; // strap level has been taken
	logic strap_ff; // pins act as static controls

	// select level taken once the synchroniser holds real pin data
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			strap_wait_ff <= 2'h0;
			strap_done_ff <= 1'b0;
			strap_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			if (strap_wait_ff == `STRAP_WAIT) begin
				strap_done_ff <= 1'b1;
				strap_ff <= sel_lvl;
			end
		end else if (!sel_lvl) begin
			strap_ff <= 1'b0; // one-way: only a new reset restores it
		end
	end

	// port live only after strap decision and out of strap mode
	logic port_en;
	assign port_en = strap_done_ff & ~strap_ff;

	// ----------------------------------------------------------------
	// frame state machine
	// ----------------------------------------------------------------
	dev_state_t state_ff; // frame phase
	logic [3:0] bit_cnt_ff; // bit within instruction or byte
	logic [15:0] instr_sh_ff; // instruction shifter
	logic [7:0] data_sh_ff; // write data shifter
	logic [1:0] wlen_ff; // word-length field
	logic [1:0] byte_cnt_ff; // bytes done in this frame
	logic [12:0] addr_ff; // current register address
	logic lsb_ff; // bit order, from port config
	logic [15:0] nxt_instr; // instruction with the new bit
	logic [7:0] nxt_data; // data byte with the new bit
	logic byte_end; // last bit of a data byte arriving
	logic frame_end; // last byte of a counted frame
	logic stall_ok; // select high here is a stall
	logic wr_en; // commit a written byte

	// shift direction follows the bit order
	assign nxt_instr = lsb_ff ? {sdio_lvl, instr_sh_ff[15:1]} : {instr_sh_ff[14:0], sdio_lvl};
	assign nxt_data = lsb_ff ? {sdio_lvl, data_sh_ff[7:1]} : {data_sh_ff[6:0], sdio_lvl};
	assign byte_end = sclk_rise & ~sel_lvl & port_en & (state_ff != DEV_INSTR)
		& (bit_cnt_ff == 4'h7);
	assign frame_end = (wlen_ff != `WLEN_STREAM) && (byte_cnt_ff == wlen_ff);
	// stall only on a byte boundary of a counted frame
	assign stall_ok = (bit_cnt_ff == 4'h0) && (state_ff != DEV_INSTR)
		&& (wlen_ff != `WLEN_STREAM);
	assign wr_en = byte_end & (state_ff == DEV_WRITE);

	// bit sequencing on synchronised rising shift clock
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= DEV_INSTR;
			bit_cnt_ff <= 4'h0;
			instr_sh_ff <= 16'h0000;
			data_sh_ff <= 8'h00;
			wlen_ff <= 2'h0;
			byte_cnt_ff <= 2'h0;
			addr_ff <= 13'h0000;
		end else if (!port_en) begin
			state_ff <= DEV_INSTR; // serial functions idle in strap mode
			bit_cnt_ff <= 4'h0;
		end else if (sel_lvl) begin
			if (!stall_ok) begin
				state_ff <= DEV_INSTR; // partial byte dropped
				bit_cnt_ff <= 4'h0;
			end
		end else if (sclk_rise) begin
			// first rise after select low opens the frame
			case (state_ff)
				DEV_INSTR: begin
					instr_sh_ff <= nxt_instr;
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == 4'(`INSTR_BITS - 1)) begin
						// rw flag, length, address
						state_ff <= nxt_instr[`INS_RW] ? DEV_READ : DEV_WRITE;
						wlen_ff <= nxt_instr[`INS_WLEN_HI:`INS_WLEN_LO];
						addr_ff <= nxt_instr[12:0];
						byte_cnt_ff <= 2'h0;
						bit_cnt_ff <= 4'h0;
					end
				end
				DEV_WRITE, DEV_READ: begin
					data_sh_ff <= nxt_data;
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
					if (bit_cnt_ff == 4'(`WORD_BITS - 1)) begin
						bit_cnt_ff <= 4'h0;
						byte_cnt_ff <= byte_cnt_ff + 2'h1;
						// address walks down msb first, up lsb first
						addr_ff <= lsb_ff ? addr_ff + 13'h1 : addr_ff - 13'h1;
						if (frame_end) begin
							state_ff <= DEV_INSTR;
						end
						// streaming keeps going while select low
					end
				end
				default: begin
					state_ff <= DEV_INSTR;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	byte_t func_ff [0:`FUNC_COUNT-1]; // converter function bytes
	logic [12:0] func_idx; // index into function bytes
	logic in_func; // address inside function region
	logic srst_req; // soft reset bit written
	byte_t rd_byte; // readback value at addr_ff

	assign func_idx = addr_ff - `ADDR_FUNC_LO;
	assign in_func = (addr_ff >= `ADDR_FUNC_LO) && (addr_ff <= `ADDR_FUNC_HI);
	assign srst_req = wr_en && (addr_ff == `ADDR_PORT_CFG)
		&& (nxt_data[`CFG_SRST_HI] || nxt_data[`CFG_SRST_LO]);

	// function bytes, defaults at reset and soft reset
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < `FUNC_COUNT; i++) begin
				func_ff[i] <= (i == (`ADDR_PHASE - `ADDR_FUNC_LO)) ? `PHASE_RST
					: `FUNC_RST;
			end
		end else if (srst_req) begin
			for (int i = 0; i < `FUNC_COUNT; i++) begin
				func_ff[i] <= (i == (`ADDR_PHASE - `ADDR_FUNC_LO)) ? `PHASE_RST
					: `FUNC_RST;
			end
		end else if (wr_en && in_func) begin
			func_ff[func_idx[4:0]] <= nxt_data;
		end
	end

	// bit order; mirrored bits in either nibble select lsb first
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			lsb_ff <= 1'b0;
		end else if (srst_req) begin
			lsb_ff <= 1'b0;
		end else if (wr_en && (addr_ff == `ADDR_PORT_CFG)) begin
			lsb_ff <= nxt_data[`CFG_LSB_HI] | nxt_data[`CFG_LSB_LO];
		end
	end

	// phase output moves only on the transfer strobe
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PHASE_ADJ <= `PHASE_RST;
		end else if (wr_en && (addr_ff == `ADDR_UPDATE) && nxt_data[`UPD_XFER]) begin
			PHASE_ADJ <= func_ff[5'(`ADDR_PHASE - `ADDR_FUNC_LO)];
		end
	end

	// readback mux; open locations read zero
	always_comb begin
		rd_byte = 8'h00;
		if (addr_ff == `ADDR_PORT_CFG) begin
			rd_byte = `PORT_CFG_RST;
			rd_byte[`CFG_LSB_HI] = lsb_ff;
			rd_byte[`CFG_LSB_LO] = lsb_ff;
		end else if (addr_ff == `ADDR_CHIP_ID) begin
			rd_byte = CHIP_ID;
		end else if (addr_ff == `ADDR_CHIP_GRADE) begin
			rd_byte[`GRADE_CHILD] = CHIP_CHILD;
		end else if (in_func) begin
			rd_byte = func_ff[func_idx[4:0]];
		end
	end

	// ----------------------------------------------------------------
	// data line driver
	// ----------------------------------------------------------------
	logic dout_ff; // driven bit
	logic doe_ff; // drive enable

	// turn around at the first fall after the instruction
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			dout_ff <= 1'b0;
			doe_ff <= 1'b0;
		end else if (!port_en || sel_lvl || state_ff != DEV_READ) begin
			doe_ff <= 1'b0; // input on writes and when idle
		end else if (sclk_fall) begin
			doe_ff <= 1'b1;
			dout_ff <= lsb_ff ? rd_byte[bit_cnt_ff[2:0]]
				: rd_byte[3'h7 - bit_cnt_ff[2:0]];
		end
	end

	assign LINK.dev_sdio_out = dout_ff;
	assign LINK.dev_sdio_oe = doe_ff;

	// ----------------------------------------------------------------
	// status and strap outputs
	// ----------------------------------------------------------------
	// static control pins only mean something in strap mode
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			FORMAT_TWOS <= 1'b0;
			STABILIZER_EN <= 1'b0;
			STRAP_MODE <= 1'b0;
			LSB_FIRST <= 1'b0;
		end else begin
			FORMAT_TWOS <= strap_ff & sclk_lvl;
			STABILIZER_EN <= strap_ff & sdio_lvl;
			STRAP_MODE <= strap_ff;
			LSB_FIRST <= lsb_ff;
		end
	end
endmodule

//--- logic/cfg_port_host.sv
// programming host: axi4-lite command registers driving the serial frame
// assumes software keeps the host bit order equal to the device setting
//
// Decided for this implementation: the AXI4-Lite slave port.
`include "cfg_port_cfg.svh"
module cfg_port_host
	import cfg_port_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	cfg_port_if.host LINK,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	// ----------------------------------------------------------------
	// command registers
	// ----------------------------------------------------------------
	host_state_t state_ff; // sequencer phase
	logic [15:0] instr_ff; // instruction to send
	logic [31:0] wdata_ff; // up to four write bytes, byte 0 low
	logic [31:0] rdata_ff; // bytes read back
	logic lsb_ff; // bit order
	logic done_ff; // frame finished
	logic wr_go; // write handshake this cycle
	logic start; // launch a frame
	logic [31:0] wmask; // byte strobes as bit mask

	assign wr_go = AWREADY & WREADY;
	assign start = wr_go && (AWADDR == `HREG_INSTR) && (state_ff == H_IDLE);
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{WSTRB[b]}};
		end
	end

	// address and data taken together, one write at a time
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
		end else begin
			AWREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
			WREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP <= (AWADDR == `HREG_INSTR || AWADDR == `HREG_WDATA
					|| AWADDR == `HREG_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// software-written fields; busy blocks changes mid-frame
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			instr_ff <= 16'h0000;
			wdata_ff <= 32'h0000_0000;
			lsb_ff <= 1'b0;
		end else if (wr_go && state_ff == H_IDLE) begin
			case (AWADDR)
				`HREG_INSTR: instr_ff <= (instr_ff & ~wmask[15:0]) | (WDATA[15:0] & wmask[15:0]);
				`HREG_WDATA: wdata_ff <= (wdata_ff & ~wmask) | (WDATA & wmask);
				`HREG_CTRL: if (WSTRB[0]) lsb_ff <= WDATA[0];
				default: begin
				end
			endcase
		end
	end

	// read channel, one cycle after address taken
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `RESP_OKAY;
		end else begin
			ARREADY <= ARVALID & ~ARREADY & ~RVALID;
			if (ARREADY) begin
				RVALID <= 1'b1;
				RRESP <= `RESP_OKAY;
				case (ARADDR)
					`HREG_INSTR: RDATA <= {16'h0000, instr_ff};
					`HREG_WDATA: RDATA <= wdata_ff;
					`HREG_RDATA: RDATA <= rdata_ff;
					`HREG_STATUS: RDATA <= {30'h0, done_ff, state_ff != H_IDLE};
					`HREG_CTRL: RDATA <= {31'h0, lsb_ff};
					default: begin
						RDATA <= 32'h0000_0000;
						RRESP <= `RESP_SLVERR;
					end
				endcase
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial sequencer
	// ----------------------------------------------------------------
	logic sclk_ff, sel_n_ff, dout_ff, doe_ff; // link drives
	logic [5:0] bit_idx_ff; // bit position in frame
	logic [3:0] tmr_ff; // half-period timer
	logic sdio_lvl; // synchronised returning data
	logic is_read; // readback frame
	logic [5:0] last_idx; // final bit of the frame
	logic [5:0] nxt_idx; // following bit
	logic [5:0] dpos; // bit position inside data phase
	logic [2:0] nbytes; // data bytes in this frame

	sync_edge u_sdio (.clk(CLOCK), .rst_n(RST_N), .din(LINK.serial_io_stabilizer_pin),
		.level(sdio_lvl), .rise(), .fall());

	assign is_read = instr_ff[`INS_RW];
	// length 0..2 gives 1..3 bytes, streaming sends four
	assign nbytes = (instr_ff[`INS_WLEN_HI:`INS_WLEN_LO] == `WLEN_STREAM) ? 3'h4
		: {1'b0, instr_ff[`INS_WLEN_HI:`INS_WLEN_LO]} + 3'h1;
	assign last_idx = 6'(`INSTR_BITS - 1) + {nbytes, 3'h0};
	assign nxt_idx = bit_idx_ff + 6'h1;
	assign dpos = bit_idx_ff - 6'(`INSTR_BITS);

	// bit value for a frame position, honouring bit order
	function automatic logic tx_bit(input logic [5:0] idx);
		logic [5:0] d;
		d = idx - 6'(`INSTR_BITS);
		if (idx < 6'(`INSTR_BITS)) begin
			tx_bit = lsb_ff ? instr_ff[idx[3:0]] : instr_ff[4'hf - idx[3:0]];
		end else begin
			tx_bit = wdata_ff[{d[4:3], lsb_ff ? d[2:0] : 3'h7 - d[2:0]}];
		end
	endfunction

	// clock divider and bit sequencing
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= H_IDLE;
			sclk_ff <= 1'b0;
			sel_n_ff <= 1'b1;
			dout_ff <= 1'b0;
			doe_ff <= 1'b0;
			bit_idx_ff <= 6'h0;
			tmr_ff <= 4'h0;
			done_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			tmr_ff <= tmr_ff - 4'h1;
			case (state_ff)
				H_IDLE: begin
					if (start) begin
						state_ff <= H_LEAD;
						sel_n_ff <= 1'b0;
						doe_ff <= 1'b1;
						bit_idx_ff <= 6'h0;
						done_ff <= 1'b0;
						rdata_ff <= 32'h0000_0000;
						tmr_ff <= 4'(`SCLK_HALF_CYC - 1);
					end
				end
				H_LEAD: begin
					// instr_ff holds the new word only from the cycle after start
					dout_ff <= tx_bit(6'h0);
					if (tmr_ff == 4'h0) begin
						state_ff <= H_SHIFT;
						sclk_ff <= 1'b1; // first rise opens the frame
						tmr_ff <= 4'(`SCLK_HALF_CYC - 1);
					end
				end
				H_SHIFT: begin
					if (tmr_ff == 4'h0) begin
						tmr_ff <= 4'(`SCLK_HALF_CYC - 1);
						if (sclk_ff) begin
							sclk_ff <= 1'b0;
							if (bit_idx_ff == last_idx) begin
								state_ff <= H_TAIL;
							end else begin
								bit_idx_ff <= nxt_idx;
								dout_ff <= tx_bit(nxt_idx); // stable across next rise
								// release line once instruction is out
								doe_ff <= ~(is_read && nxt_idx >= 6'(`INSTR_BITS));
							end
						end else begin
							sclk_ff <= 1'b1;
							if (is_read && bit_idx_ff >= 6'(`INSTR_BITS)) begin
								rdata_ff[{dpos[4:3], lsb_ff ? dpos[2:0] : 3'h7 - dpos[2:0]}]
									<= sdio_lvl;
							end
						end
					end
				end
				H_TAIL: begin
					if (tmr_ff == 4'h0) begin
						state_ff <= H_IDLE;
						sel_n_ff <= 1'b1; // ends frame, also ends streaming
						doe_ff <= 1'b0;
						done_ff <= 1'b1;
					end
				end
				default: begin
					state_ff <= H_IDLE;
				end
			endcase
		end
	end

	assign LINK.shift_clock_format_pin = sclk_ff;
	assign LINK.port_select_n = sel_n_ff;
	assign LINK.host_sdio_out = dout_ff;
	assign LINK.host_sdio_oe = doe_ff;
endmodule

//--- logic/cfg_port_if.sv
// link between programming host and converter configuration port
// assumes an idle pull-up on the data line when neither end drives
interface cfg_port_if;
	logic shift_clock_format_pin; // host shift clock, strap format level
	logic port_select_n; // active-low frame select
	logic host_sdio_out; // host data drive value
	logic host_sdio_oe; // host drives data line
	logic dev_sdio_out; // device data drive value
	logic dev_sdio_oe; // device drives data line
	logic serial_io_stabilizer_pin; // resolved data line level

	// wire resolution, pull-up when released
	assign serial_io_stabilizer_pin = dev_sdio_oe ? dev_sdio_out :
		(host_sdio_oe ? host_sdio_out : 1'b1);

	modport dev(input shift_clock_format_pin, input port_select_n,
		input serial_io_stabilizer_pin, output dev_sdio_out, output dev_sdio_oe);
	modport host(output shift_clock_format_pin, output port_select_n,
		output host_sdio_out, output host_sdio_oe, input serial_io_stabilizer_pin);
endinterface

//--- logic/cfg_port_pkg.sv
// types shared by both ends of the configuration port
// assumes nothing beyond a systemverilog compiler
package cfg_port_pkg;
	// device frame phases
	typedef enum logic [1:0] {DEV_INSTR, DEV_WRITE, DEV_READ} dev_state_t;
	// host sequencer phases
	typedef enum logic [1:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL} host_state_t;
	typedef logic [7:0] byte_t;
endpackage

//--- logic/sync_edge.sv
// two-flop synchroniser with edge detection on the synchronised level
// assumes din is asynchronous to clk
module sync_edge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_ff; // first stage, read only by level_ff
	logic level_ff; // synchronised level
	logic prev_ff; // level one cycle back

	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			level_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= din;
			level_ff <= meta_ff;
			prev_ff <= level_ff;
		end
	end

	assign level = level_ff;
	assign rise = level_ff & ~prev_ff;
	assign fall = ~level_ff & prev_ff;
endmodule
